// file: core/sar_adc_sequencer.sv
// Purpose: sequencing of a 10-bit successive-approximation converter
// Assumes: software control bits come from sys_clk logic; rc clock and comparator come from the analog side
// Notes:   the analog array is outside; this block steers it and captures its decisions
// Summary of operation
// - bit period from clock select: /2,/4,/8,/16,/32,/64 or dedicated rc clock
// - a full conversion takes eleven bit periods
// - system-derived periods scale with the system clock rate
// - done flag set at every completed conversion regardless of irq enable
// - with irq enable, completion raises interrupt, running or asleep, and wakes
// - result placed left or right justified as selected
// - left: high=9..2, low top=1..0; right: high low=9..8, low=7..0
// - converter on first, then writing go starts a conversion
// - completion clears go, sets done flag, loads both result bytes
// - clearing go early aborts and keeps the previous result
// - after abort wait for two ticks of the running bit-period divider (not restarted), then start acquisition again
// - reset returns registers to reset values and ends any conversion
// - rc clock delays start one instruction cycle; sleep conversion only with it
// - sleep completion without irq enable powers down, converter_on stays set
// - sleep with a non-rc clock aborts and powers down, converter_on stays set
// - special event trigger sets go and resets the sixteen bit timer
// - channel select routes inputs 0..11, comparator ref, fixed ref; 14,15 reserved
`timescale 1ns/1ps
module sar_adc_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       converter_on,
   input  wire logic       go_write,
   input  wire logic       go_write_value,
   input  wire logic       done_flag_clear,
   input  wire logic       conv_irq_enable,
   input  wire logic       result_justify_select,
   input  wire logic [2:0] conv_clock_select,
   input  wire logic [3:0] channel_select,
   input  wire logic       sleep_active,
   input  wire logic       special_event_trigger,
   input  wire logic       rc_clock_pin,
   input  wire logic       comparator_pin,
   output logic            conv_go_busy,
   output logic            conv_done_flag,
   output logic            conv_irq,
   output logic            wake_request,
   output logic [7:0]      result_high_byte,
   output logic [7:0]      result_low_byte,
   output logic            timer_reset,
   output logic            analog_powered,
   output logic            acquire_enable,
   output logic [9:0]      dac_trial,
   output mux_route_s      mux_route
);

   logic [2:0]   rc_sync_reg;
   logic [1:0]   cmp_sync_reg;
   logic         rc_tick;
   logic         tad_tick;
   logic         restart;
   seq_state_e   state_reg,  state_next;
   logic [3:0]   cnt_reg,    cnt_next;
   logic [9:0]   sar_reg,    sar_next;
   logic         go_reg,     go_next;
   logic         done_reg,   done_next;
   logic         irq_reg,    irq_next;
   logic         wake_reg,   wake_next;
   logic         tmr_reg,    tmr_next;
   logic         pwr_reg,    pwr_next;
   logic         acq_reg,    acq_next;
   logic         parked_reg, parked_next;
   result_pair_s res_reg,    res_next;
   mux_route_s   route_reg,  route_next;
   logic         go_req;
   logic         rc_sel;

   function automatic result_pair_s justify(input logic [9:0] v, input logic right);
      if (right)
      begin
         justify = '{high_byte: {6'h00, v[9:8]}, low_byte: v[7:0]};
      end
      else
      begin
         justify = '{high_byte: v[9:2], low_byte: {v[1:0], 6'h00}};
      end
   endfunction : justify

   // edge detector reads only the second and third stages
   // limitation: at /2 the comparator sync lags one bit period, too fast for the analog side anyway
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rc_sync_reg  <= 3'h0;
         cmp_sync_reg <= 2'h0;
      end
      else
      begin
         rc_sync_reg  <= {rc_sync_reg[1:0], rc_clock_pin};
         cmp_sync_reg <= {cmp_sync_reg[0], comparator_pin};
      end
   end

   assign rc_tick = rc_sync_reg[1] & ~rc_sync_reg[2];
   assign rc_sel  = (conv_clock_select[1:0] == CS_RC_LOW);
   assign go_req  = (go_write & go_write_value) | special_event_trigger;
   assign restart = (state_reg != ST_CONV) && (state_reg != ST_ABORT);

   tad_divider u_tad
   (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .restart  (restart),
      .clk_sel  (conv_clock_select),
      .rc_tick  (rc_tick),
      .tad_tick (tad_tick)
   );

   always_comb
   begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      sar_next    = sar_reg;
      go_next     = go_reg;
      res_next    = res_reg;
      parked_next = parked_reg;
      pwr_next    = converter_on & ~parked_reg;
      acq_next    = 1'b0;
      tmr_next    = special_event_trigger & converter_on;
      // route table; reserved codes drive nothing
      route_next  = '{sel_valid: (channel_select <= CH_LAST_ANALOG), analog_index: channel_select,
                      comp_ref: (channel_select == CH_COMP_REF), fixed_ref: (channel_select == CH_FIXED_REF)};
      // set wins over software clear
      done_next   = done_reg & ~done_flag_clear;
      if (!sleep_active)
      begin
         parked_next = 1'b0;
      end
      unique case (state_reg)
         ST_OFF :
         begin
            go_next = 1'b0;
            if (converter_on && !parked_reg)
            begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE :
         begin
            acq_next = 1'b1;
            if (!converter_on || parked_reg)
            begin
               state_next = ST_OFF;
            end
            else if (go_req && !(sleep_active && !rc_sel))
            begin
               go_next    = 1'b1;
               cnt_next   = rc_sel ? RC_START_CYCLES : 4'h0;
               sar_next   = 10'h200;
               state_next = rc_sel ? ST_DELAY : ST_CONV;
            end
         end
         ST_DELAY :
         begin
            cnt_next = cnt_reg - 4'h1;
            if (go_write && !go_write_value)
            begin
               go_next    = 1'b0;
               state_next = ST_IDLE;
            end
            else if (cnt_reg == 4'h1)
            begin
               cnt_next   = 4'h0;
               state_next = ST_CONV;
            end
         end
         ST_CONV :
         begin
            // a second go write changes nothing here
            if ((go_write && !go_write_value) || (sleep_active && !rc_sel) || !converter_on)
            begin
               go_next    = 1'b0;
               cnt_next   = 4'h0;
               parked_next = sleep_active & ~rc_sel;
               state_next = ST_ABORT;
            end
            else if (tad_tick)
            begin
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg != 4'h0)
               begin
                  sar_next = (sar_reg & ~((10'h200 >> (cnt_reg - 4'h1)) & {10{~cmp_sync_reg[1]}}))
                             | (10'h100 >> (cnt_reg - 4'h1));
               end
               if (cnt_reg == CONV_PERIODS - 4'h1)
               begin
                  go_next    = 1'b0;
                  done_next  = 1'b1;
                  res_next   = justify(sar_next, result_justify_select);
                  parked_next = sleep_active & ~conv_irq_enable;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_ABORT :
         begin
            if (tad_tick || parked_reg)
            begin
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == ABORT_PERIODS - 4'h1 || parked_reg)
               begin
                  state_next = ST_IDLE;
               end
            end
         end
         default :
         begin
            state_next = ST_OFF;
         end
      endcase
      irq_next  = done_next & conv_irq_enable;
      wake_next = done_next & conv_irq_enable & sleep_active;
   end

   // every register resets; result bytes reset to zero here
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg  <= ST_OFF;
         cnt_reg    <= 4'h0;
         sar_reg    <= 10'h000;
         go_reg     <= 1'b0;
         done_reg   <= 1'b0;
         irq_reg    <= 1'b0;
         wake_reg   <= 1'b0;
         tmr_reg    <= 1'b0;
         pwr_reg    <= 1'b0;
         acq_reg    <= 1'b0;
         parked_reg <= 1'b0;
         res_reg    <= '0;
         route_reg  <= '0;
      end
      else
      begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         sar_reg    <= sar_next;
         go_reg     <= go_next;
         done_reg   <= done_next;
         irq_reg    <= irq_next;
         wake_reg   <= wake_next;
         tmr_reg    <= tmr_next;
         pwr_reg    <= pwr_next;
         acq_reg    <= acq_next;
         parked_reg <= parked_next;
         res_reg    <= res_next;
         route_reg  <= route_next;
      end
   end

   assign conv_go_busy     = go_reg;
   assign conv_done_flag   = done_reg;
   assign conv_irq         = irq_reg;
   assign wake_request     = wake_reg;
   assign result_high_byte = res_reg.high_byte;
   assign result_low_byte  = res_reg.low_byte;
   assign timer_reset      = tmr_reg;
   assign analog_powered   = pwr_reg;
   assign acquire_enable   = acq_reg;
   assign dac_trial        = sar_reg;
   assign mux_route        = route_reg;

   sequence s_finish;
      (state_reg == ST_CONV) && tad_tick && (cnt_reg == 4'hA) && !(go_write && !go_write_value)
         && converter_on && !(sleep_active && !rc_sel);
   endsequence

   sequence s_rc_start;
      (state_reg == ST_IDLE) && go_req && rc_sel && converter_on && !parked_reg;
   endsequence

   a_done_on_finish : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_finish |=> conv_done_flag && !conv_go_busy) else $error("done flag not set on completion");
   a_abort_keeps_result : assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_reg == ST_ABORT) |-> $stable(res_reg)) else $error("result changed after abort");
   a_go_ignored_busy : assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_reg == ST_CONV) && go_write && go_write_value && !tad_tick && converter_on
         && !(sleep_active && !rc_sel)
         |=> (state_reg == ST_CONV) && $stable(cnt_reg) && $stable(sar_reg))
      else $error("go during conversion restarted it");
   a_rc_delay : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_rc_start |=> (state_reg == ST_DELAY) && (cnt_reg == RC_START_CYCLES)) else $error("rc start not delayed");
   a_flag_sticky : assert property (@(posedge sys_clk) disable iff (!resetn)
      conv_done_flag && !done_flag_clear |=> conv_done_flag) else $error("done flag dropped");
   a_irq_follows : assert property (@(posedge sys_clk) disable iff (!resetn)
      conv_done_flag && conv_irq_enable && $past(conv_irq_enable) && $past(conv_done_flag) |-> conv_irq)
      else $error("interrupt missing");
   a_trigger_timer : assert property (@(posedge sys_clk) disable iff (!resetn)
      special_event_trigger && converter_on |=> timer_reset) else $error("timer not reset");
   a_abort_two : assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_reg == ST_CONV) && go_write && !go_write_value && !parked_next |=> (state_reg == ST_ABORT)[*2])
      else $error("abort wait too short");
   a_justify_left : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_finish and !result_justify_select |=> result_low_byte[5:0] == 6'h00) else $error("left format wrong");
   a_justify_right : assert property (@(posedge sys_clk) disable iff (!resetn)
      s_finish and result_justify_select |=> result_high_byte[7:2] == 6'h00) else $error("right format wrong");

endmodule : sar_adc_sequencer

// file: core/tad_divider.sv
// Purpose: one-cycle enable at the selected bit period
// Assumes: rc_tick is already synchronised to sys_clk
// Notes:   restart aligns the first period to the start of a conversion
`timescale 1ns/1ps
module tad_divider
   import adc_seq_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       restart,
   input  wire logic [2:0] clk_sel,
   input  wire logic       rc_tick,
   output logic            tad_tick
);

   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic       tick_reg;
   logic       tick_next;

   function automatic logic [5:0] div_limit(input logic [2:0] sel);
      unique case (sel)
         CS_DIV2  : div_limit = 6'h01;
         CS_DIV4  : div_limit = 6'h03;
         CS_DIV8  : div_limit = 6'h07;
         CS_DIV16 : div_limit = 6'h0F;
         CS_DIV32 : div_limit = 6'h1F;
         CS_DIV64 : div_limit = DIV_MAX;
         default  : div_limit = 6'h01;
      endcase
   endfunction : div_limit

   // system-derived periods track any change of sys_clk rate
   always_comb
   begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (restart)
      begin
         cnt_next = 6'h00;
      end
      else if (clk_sel[1:0] == CS_RC_LOW)
      begin
         tick_next = rc_tick;
      end
      else if (cnt_reg >= div_limit(clk_sel))
      begin
         cnt_next  = 6'h00;
         tick_next = 1'b1;
      end
      else
      begin
         cnt_next = cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_reg  <= 6'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tad_tick = tick_reg;

endmodule : tad_divider

// file: shared/adc_seq_pkg.sv
// Purpose: constants and types shared by the converter sequencer
// Assumes: sys_clk is the system oscillator, 125 MHz
// Notes:   clock select codes and channel codes follow the control fields
package adc_seq_pkg;

   localparam int          CLK_PERIOD_NS     = 8;
   localparam logic [2:0]  CS_DIV2           = 3'h0;
   localparam logic [2:0]  CS_DIV4           = 3'h4;
   localparam logic [2:0]  CS_DIV8           = 3'h1;
   localparam logic [2:0]  CS_DIV16          = 3'h5;
   localparam logic [2:0]  CS_DIV32          = 3'h2;
   localparam logic [2:0]  CS_DIV64          = 3'h6;
   localparam logic [1:0]  CS_RC_LOW         = 2'h3;
   localparam logic [3:0]  CONV_PERIODS      = 4'hB;
   localparam logic [3:0]  ABORT_PERIODS     = 4'h2;
   localparam logic [3:0]  RC_START_CYCLES   = 4'h4;
   localparam logic [3:0]  CH_LAST_ANALOG    = 4'hB;
   localparam logic [3:0]  CH_COMP_REF       = 4'hC;
   localparam logic [3:0]  CH_FIXED_REF      = 4'hD;
   localparam logic [5:0]  DIV_MAX           = 6'h3F;
   localparam int          RESULT_BITS       = 10;

   typedef struct packed
   {
      logic [7:0] high_byte;
      logic [7:0] low_byte;
   } result_pair_s;

   typedef struct packed
   {
      logic       sel_valid;
      logic [3:0] analog_index;
      logic       comp_ref;
      logic       fixed_ref;
   } mux_route_s;

   typedef enum logic [4:0]
   {
      ST_OFF   = 5'h01,
      ST_IDLE  = 5'h02,
      ST_DELAY = 5'h04,
      ST_CONV  = 5'h08,
      ST_ABORT = 5'h10
   } seq_state_e;

endpackage : adc_seq_pkg

// file: testbench/analog_model.sv
// Purpose: analog side of the converter: dedicated rc clock and sar comparator
// Assumes: target is the input voltage as a 10-bit code, held for a whole conversion
// Notes:   rc clock stands still while not selected; comparator output toggles while unpowered
`timescale 1ns/1ps
module analog_model
(
   input  wire logic       sys_clk,
   input  wire logic       rc_run,
   input  wire logic       analog_powered,
   input  wire logic [9:0] target,
   input  wire logic [9:0] dac_trial,
   output logic            rc_clock_pin,
   output logic            comparator_pin
);
   logic flip = 1'b0;
   // rc period is unrelated to sys_clk so the design sees arbitrary phase
   initial
   begin
      rc_clock_pin = 1'b0;
      forever
      begin
         #23.0;
         rc_clock_pin = rc_run ? ~rc_clock_pin : 1'b0;
      end
   end
   always @(posedge sys_clk) flip <= ~flip;
   // unpowered comparator gives no stable decision, never the last value
   assign comparator_pin = analog_powered ? (dac_trial <= target) : flip;
endmodule : analog_model

// file: testbench/test_sar_adc_sequencer.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: conversion lengths differ by exactly 11 x divisor step
// Notes:   inputs change on the falling edge; reserved result bits expected zero
`timescale 1ns/1ps
module test_sar_adc_sequencer
   import adc_seq_pkg::*;
;
   logic sys_clk, resetn, converter_on, go_write, go_write_value, done_flag_clear;
   logic conv_irq_enable, result_justify_select, sleep_active, special_event_trigger;
   logic [2:0] conv_clock_select;
   logic [3:0] channel_select;
   logic [9:0] target, dac_trial;
   logic rc_clock_pin, comparator_pin, conv_go_busy, conv_done_flag, conv_irq, wake_request;
   logic timer_reset, analog_powered, acquire_enable;
   logic [7:0] result_high_byte, result_low_byte, keep_h, keep_l;
   mux_route_s mux_route;
   int fails, samples_checked, cyc, base, ticks, i, n;
   typedef struct { logic [2:0] cs; int dv; logic js; logic ie; logic [9:0] tg; } row_s;
   row_s rows [6] = '{'{3'h0, 2, 1'b1, 1'b0, 10'h3FF}, '{3'h4, 4, 1'b0, 1'b1, 10'h000},
      '{3'h1, 8, 1'b1, 1'b1, 10'h2A5}, '{3'h5, 16, 1'b0, 1'b0, 10'h15A},
      '{3'h2, 32, 1'b1, 1'b0, 10'h201}, '{3'h6, 64, 1'b0, 1'b1, 10'h1FE}};

   sar_adc_sequencer sar_adc_sequencer_inst (.sys_clk(sys_clk), .resetn(resetn), .converter_on(converter_on),
      .go_write(go_write), .go_write_value(go_write_value), .done_flag_clear(done_flag_clear),
      .conv_irq_enable(conv_irq_enable), .result_justify_select(result_justify_select),
      .conv_clock_select(conv_clock_select), .channel_select(channel_select), .sleep_active(sleep_active),
      .special_event_trigger(special_event_trigger), .rc_clock_pin(rc_clock_pin),
      .comparator_pin(comparator_pin), .conv_go_busy(conv_go_busy), .conv_done_flag(conv_done_flag),
      .conv_irq(conv_irq), .wake_request(wake_request), .result_high_byte(result_high_byte),
      .result_low_byte(result_low_byte), .timer_reset(timer_reset), .analog_powered(analog_powered),
      .acquire_enable(acquire_enable), .dac_trial(dac_trial), .mux_route(mux_route));
   analog_model analog_model_inst (.sys_clk(sys_clk), .rc_run(conv_clock_select[1:0] == CS_RC_LOW),
      .analog_powered(analog_powered), .target(target), .dac_trial(dac_trial),
      .rc_clock_pin(rc_clock_pin), .comparator_pin(comparator_pin));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial
   begin
      ticks = 0;
      forever
      begin
         @(posedge sys_clk);
         ticks++;
         if (ticks == 20000)
         begin
            fails++;
            stop_test();
         end
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic cyc_wait(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : cyc_wait
   task automatic write_go(input logic v);
      go_write = 1'b1;
      go_write_value = v;
      @(negedge sys_clk);
      go_write = 1'b0;
   endtask : write_go
   // polls busy until low, as software does before reading results; extra go lands mid-run
   task automatic run_conv(input logic extra);
      write_go(1'b1);
      check("busy_start", conv_go_busy, 16'h1);
      cyc = 1;
      while (conv_go_busy !== 1'b0 && cyc < 3000)
      begin
         go_write = extra && (cyc == 10);
         go_write_value = 1'b1;
         @(negedge sys_clk);
         cyc++;
      end
      cyc_wait(1);
   endtask : run_conv
   task automatic check_result(input logic js, input logic [9:0] t);
      check("res_high", result_high_byte, js ? {6'h00, t[9:8]} : t[9:2]);
      check("res_low", result_low_byte, js ? t[7:0] : {t[1:0], 6'h00});
   endtask : check_result
   task automatic clear_done();
      done_flag_clear = 1'b1;
      @(negedge sys_clk);
      done_flag_clear = 1'b0;
      cyc_wait(1);
      check("done_cleared", conv_done_flag, 16'h0);
   endtask : clear_done

   initial
   begin
      fails = 0;
      samples_checked = 0;
      {resetn, converter_on, go_write, go_write_value, done_flag_clear, conv_irq_enable} = '0;
      {result_justify_select, sleep_active, special_event_trigger} = '0;
      conv_clock_select = 3'h0;
      channel_select = 4'h0;
      target = 10'h000;
      cyc_wait(16);
      resetn = 1'b1;
      cyc_wait(1);
      converter_on = 1'b1; // on in an earlier write than go
      cyc_wait(3);
      for (i = 0; i < 16; i++)
      begin
         channel_select = i[3:0];
         cyc_wait(2);
         check("route_valid", mux_route.sel_valid, {15'h0, i < 12});
         check("route_comp", mux_route.comp_ref, {15'h0, i == 12});
         check("route_fixed", mux_route.fixed_ref, {15'h0, i == 13});
         if (i < 12)
            check("route_index", mux_route.analog_index, i[15:0]);
      end
      channel_select = 4'h0;
      cyc_wait(8); // acquisition time after the channel change
      for (i = 0; i < 6; i++)
      begin
         {conv_clock_select, result_justify_select, conv_irq_enable, target} =
            {rows[i].cs, rows[i].js, rows[i].ie, rows[i].tg};
         cyc_wait(2);
         run_conv(1'b0);
         if (i == 0)
            base = cyc;
         check("conv_length", cyc[15:0], 16'(base + 11 * (rows[i].dv - 2)));
         check_result(rows[i].js, rows[i].tg);
         cyc_wait(6);
         check("done_set", conv_done_flag, 16'h1);
         check("irq", conv_irq, {15'h0, rows[i].ie});
         clear_done();
      end
      // go written during a running conversion changes nothing
      conv_clock_select = CS_DIV8;
      result_justify_select = 1'b1;
      target = 10'h0C3;
      run_conv(1'b1);
      check("go_ignored", cyc[15:0], 16'(base + 66));
      check_result(1'b1, 10'h0C3);
      clear_done();
      // abort keeps old result, next go refused during the abort wait
      conv_clock_select = CS_DIV64;
      target = 10'h111;
      write_go(1'b1);
      cyc_wait(60);
      write_go(1'b0);
      cyc_wait(2);
      check("abort_busy", conv_go_busy, 16'h0);
      write_go(1'b1);
      cyc_wait(1);
      check("abort_refuse", conv_go_busy, 16'h0);
      check("abort_acq", acquire_enable, 16'h0);
      check_result(1'b1, 10'h0C3);
      cyc_wait(140);
      check("abort_reacquire", acquire_enable, 16'h1);
      run_conv(1'b0);
      check_result(1'b1, 10'h111);
      clear_done();
      // special event trigger starts a conversion and resets the timer
      special_event_trigger = 1'b1;
      @(negedge sys_clk);
      special_event_trigger = 1'b0;
      n = 0;
      for (i = 0; i < 3; i++)
      begin
         n += (timer_reset === 1'b1);
         cyc_wait(1);
      end
      check("trig_busy", conv_go_busy, 16'h1);
      check("trig_timer", n[15:0], 16'h1);
      cyc_wait(800);
      check("trig_done", conv_done_flag, 16'h1);
      clear_done();
      // sleep with a system clock choice aborts and powers down
      write_go(1'b1);
      cyc_wait(30);
      sleep_active = 1'b1;
      cyc_wait(4);
      check("sleep_abort", conv_go_busy, 16'h0);
      check("sleep_power", analog_powered, 16'h0);
      check_result(1'b1, 10'h111);
      sleep_active = 1'b0;
      cyc_wait(200);
      // rc clock conversions finish in sleep: wake with irq, power down without
      conv_clock_select = 3'h3;
      for (i = 0; i < 2; i++)
      begin
         conv_irq_enable = (i == 0);
         target = i ? 10'h3A0 : 10'h05F;
         write_go(1'b1);
         sleep_active = 1'b1;
         n = 0;
         while (conv_go_busy !== 1'b0 && n < 2000)
         begin
            cyc_wait(1);
            n++;
         end
         cyc_wait(3);
         check("rc_done", conv_done_flag, 16'h1);
         check("rc_wake", wake_request, {15'h0, i == 0});
         check_result(1'b1, target);
         if (i == 1)
            check("rc_park", analog_powered, 16'h0);
         sleep_active = 1'b0;
         cyc_wait(4);
         clear_done();
      end
      // reset in mid-conversion
      conv_clock_select = CS_DIV64;
      write_go(1'b1);
      cyc_wait(40);
      resetn = 1'b0;
      cyc_wait(2);
      check("rst_busy", conv_go_busy, 16'h0);
      check("rst_power", analog_powered, 16'h0);
      check("rst_res", {result_high_byte, result_low_byte}, 16'h0000);
      resetn = 1'b1;
      cyc_wait(4);
      check("rst_go", conv_go_busy, 16'h0);
      check("rst_idle", acquire_enable, 16'h1);
      stop_test();
   end
endmodule : test_sar_adc_sequencer
